// ### led_sink_defines.vh
// Purpose: constants for the LED sink current control register bank
// Assumes: byte-wide registers at the device register addresses
// Notes:   reset values are all zero
`ifndef LED_SINK_DEFINES_VH
`define LED_SINK_DEFINES_VH

// register addresses
`define ADDR_BACKLIGHT_DIM_CURRENT 8'h0a
`define ADDR_SINK_FADE_LAW_SELECT  8'h0f
`define ADDR_SINK_ENABLE_CONTROL   8'h10

// reset values
`define RST_BACKLIGHT_DIM_CURRENT  7'h00
`define RST_SINK_FADE_LAW_SELECT   2'h0
`define RST_SINK_ENABLE_CONTROL    7'h00

// field layout
`define DIM_CODE_MSB               6
`define FADE_LAW_MSB               1
`define SINK_EN_MSB                6

// fade law encodings
`define LAW_LINEAR                 2'h0
`define LAW_SQUARE                 2'h1
`define LAW_CUBIC_A                2'h2
`define LAW_CUBIC_B                2'h3

// full-scale current in microamps and code span
`define FULL_SCALE_UA              32'h7530
`define CODE_MAX                   32'h7f
`define CODE_MAX_SQ                32'h3f01

// dwell weight of one code step for linear time steps
`define DWELL_UNIT                 8'h01

`endif

// ### code_to_current.v
// Purpose: maps a seven-bit current code and fade law to sink current and step dwell
// Assumes: combinational, same clock domain as its user
// Notes:   current is in microamps, truncated
`default_nettype none
`include "led_sink_defines.vh"

module code_to_current (
  // code and law
  input  wire [6:0]  code_i,
  input  wire [1:0]  law_i,
  // mapped results
  output reg  [14:0] current_ua_o,
  output reg  [7:0]  dwell_o
);

  reg [31:0] lin_ua;
  reg [31:0] sq_ua;

  always @* begin
    lin_ua = ({25'h0, code_i} * `FULL_SCALE_UA) / `CODE_MAX;
    sq_ua  = ({25'h0, code_i} * {25'h0, code_i} * `FULL_SCALE_UA) / `CODE_MAX_SQ;
    if (law_i == `LAW_LINEAR) begin
      current_ua_o = lin_ua[14:0];
    end else begin
      current_ua_o = sq_ua[14:0];
    end
    case (law_i)
      `LAW_CUBIC_A: dwell_o = `DWELL_UNIT + {4'h0, 4'hf - code_i[6:3]};
      `LAW_CUBIC_B: dwell_o = `DWELL_UNIT + {4'h0, code_i[6:3]};
      default:      dwell_o = `DWELL_UNIT;
    endcase
  end

endmodule // code_to_current
`default_nettype wire

// ### led_sink_current_control.v
// Purpose: register bank for backlight dim current, sink fade law and sink enables
// Assumes: register port driven by the serial interface engine on CORE_CLK_I
// Notes:   25 MHz core clock, synchronous active-low reset
`default_nettype none
`include "led_sink_defines.vh"

module led_sink_current_control (
  // clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  // register port
  input  wire [7:0]  REG_ADDR_I,
  input  wire [7:0]  REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [7:0]  REG_RDATA_O,
  output reg         REG_HIT_O,
  // backlight dimming
  input  wire        DIM_TIMEOUT_I,
  input  wire        DIM_REQ_I,
  input  wire [6:0]  BL_ACTIVE_CODE_I,
  output reg  [6:0]  BL_CODE_O,
  output reg         BL_DIMMED_O,
  // sink fading
  input  wire [6:0]  FADE_CODE_I,
  output reg  [14:0] SINK_CURRENT_UA_O,
  output reg  [7:0]  STEP_DWELL_O,
  output wire [1:0]  SINK_FADE_LAW_O,
  // sink enables
  output wire [6:0]  SINK_ENABLE_O
);

  // register state
  reg  [6:0]  dim_current_code;
  reg  [1:0]  sink_fade_law;
  reg  [6:0]  sink_enable;
  reg         dimmed;
  // next values of the register state
  reg  [6:0]  next_dim_current_code;
  reg  [1:0]  next_sink_fade_law;
  reg  [6:0]  next_sink_enable;
  reg         next_dimmed;
  // read path
  reg  [7:0]  next_rdata;
  reg         next_hit;
  // backlight path
  reg  [6:0]  next_bl_code;
  reg         next_bl_dimmed;
  // address decode
  wire        sel_dim;
  wire        sel_law;
  wire        sel_en;
  wire        wr_dim;
  wire        wr_law;
  wire        wr_en;
  wire        dim_event;
  // register words as read back, reserved bits zero
  wire [7:0]  word_dim;
  wire [7:0]  word_law;
  wire [7:0]  word_en;
  // law mapper results
  wire [14:0] map_current;
  wire [7:0]  map_dwell;

  // address decode; unmapped addresses select nothing
  assign sel_dim = (REG_ADDR_I == `ADDR_BACKLIGHT_DIM_CURRENT);
  assign sel_law = (REG_ADDR_I == `ADDR_SINK_FADE_LAW_SELECT);
  assign sel_en  = (REG_ADDR_I == `ADDR_SINK_ENABLE_CONTROL);
  assign wr_dim  = REG_WR_I & sel_dim;
  assign wr_law  = REG_WR_I & sel_law;
  assign wr_en   = REG_WR_I & sel_en;

  // next value of each register: only the defined field is taken
  always @* begin
    next_dim_current_code = dim_current_code;
    next_sink_fade_law    = sink_fade_law;
    next_sink_enable      = sink_enable;
    if (wr_dim) begin
      next_dim_current_code = REG_WDATA_I[`DIM_CODE_MSB:0];
    end
    if (wr_law) begin
      next_sink_fade_law = REG_WDATA_I[`FADE_LAW_MSB:0];
    end
    if (wr_en) begin
      next_sink_enable = REG_WDATA_I[`SINK_EN_MSB:0];
    end
  end

  // backlight dim current register
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      dim_current_code <= `RST_BACKLIGHT_DIM_CURRENT;
    end else begin
      dim_current_code <= next_dim_current_code;
    end
  end

  // sink fade law register
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      sink_fade_law <= `RST_SINK_FADE_LAW_SELECT;
    end else begin
      sink_fade_law <= next_sink_fade_law;
    end
  end

  // sink enable register
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      sink_enable <= `RST_SINK_ENABLE_CONTROL;
    end else begin
      sink_enable <= next_sink_enable;
    end
  end

  // read words with reserved bits forced low
  assign word_dim = {1'b0, dim_current_code};
  assign word_law = {6'h00, sink_fade_law};
  assign word_en  = {1'b0, sink_enable};

  // read mux
  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    case (REG_ADDR_I)
      `ADDR_BACKLIGHT_DIM_CURRENT: next_rdata = word_dim;
      `ADDR_SINK_FADE_LAW_SELECT:  next_rdata = word_law;
      `ADDR_SINK_ENABLE_CONTROL:   next_rdata = word_en;
      default:                     next_hit   = 1'b0;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
      REG_HIT_O   <= 1'b0;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= next_rdata;
      REG_HIT_O   <= next_hit;
    end
  end

  // dim event: a timeout pulse or the request level
  assign dim_event = DIM_TIMEOUT_I | DIM_REQ_I;

  // dim state latches on the first event and leaves only by reset
  always @* begin
    next_dimmed = dimmed;
    if (dim_event) begin
      next_dimmed = 1'b1;
    end
  end

  // dim state register
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      dimmed <= 1'b0;
    end else begin
      dimmed <= next_dimmed;
    end
  end

  // backlight code: the dim code from the edge of the event on
  always @* begin
    next_bl_dimmed = dimmed | dim_event;
    if (next_bl_dimmed) begin
      next_bl_code = dim_current_code;
    end else begin
      next_bl_code = BL_ACTIVE_CODE_I;
    end
  end

  // backlight outputs
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      BL_CODE_O   <= 7'h00;
      BL_DIMMED_O <= 1'b0;
    end else begin
      BL_CODE_O   <= next_bl_code;
      BL_DIMMED_O <= next_bl_dimmed;
    end
  end

  // law mapping of the sink fade code
  code_to_current u_map (
    .code_i       (FADE_CODE_I),
    .law_i        (sink_fade_law),
    .current_ua_o (map_current),
    .dwell_o      (map_dwell)
  );

  // sink current output
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      SINK_CURRENT_UA_O <= 15'h0000;
    end else begin
      SINK_CURRENT_UA_O <= map_current;
    end
  end

  // step dwell output
  always @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      STEP_DWELL_O <= 8'h00;
    end else begin
      STEP_DWELL_O <= map_dwell;
    end
  end

  // register fields seen by the sink stage
  assign SINK_FADE_LAW_O = sink_fade_law;
  assign SINK_ENABLE_O   = sink_enable;

endmodule // led_sink_current_control
`default_nettype wire

// ### led_sink_chk.sv
// Purpose: port assertions for the sink register bank
// Assumes: one clock, synchronous low reset
// Notes: bound to the top module
`default_nettype none
module led_sink_chk (
  input wire logic CORE_CLK_I, RST_N_I, REG_WR_I, REG_RD_I, REG_HIT_O,
  input wire logic DIM_TIMEOUT_I, DIM_REQ_I, BL_DIMMED_O,
  input wire logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
  input wire logic [6:0] FADE_CODE_I, SINK_ENABLE_O,
  input wire logic [14:0] SINK_CURRENT_UA_O,
  input wire logic [1:0] SINK_FADE_LAW_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_a; REG_RD_I && REG_ADDR_I == 8'h0a |=> !REG_RDATA_O[7]; endproperty
  a_a: assert property (p_a) else $error("dim bit7 set");
  property p_b; DIM_TIMEOUT_I || DIM_REQ_I |=> BL_DIMMED_O; endproperty
  a_b: assert property (p_b) else $error("no dim");
  property p_c; BL_DIMMED_O |=> BL_DIMMED_O; endproperty
  a_c: assert property (p_c) else $error("dim lost");
  property p_d; FADE_CODE_I == 7'h7f |=> SINK_CURRENT_UA_O == 15'h7530; endproperty
  a_d: assert property (p_d) else $error("full scale");
  property p_e; REG_WR_I && REG_ADDR_I == 8'h0f |=> SINK_FADE_LAW_O == ($past(REG_WDATA_I) & 8'h03); endproperty
  a_e: assert property (p_e) else $error("law");
  property p_f; REG_WR_I && REG_ADDR_I == 8'h10 |=> SINK_ENABLE_O == ($past(REG_WDATA_I) & 8'h7f); endproperty
  a_f: assert property (p_f) else $error("enable");
  property p_g; REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h10 |=> REG_RDATA_O == SINK_ENABLE_O && REG_HIT_O; endproperty
  a_g: assert property (p_g) else $error("readback");
  property p_h; REG_RD_I && !(REG_ADDR_I inside {8'h0a, 8'h0f, 8'h10}) |=> REG_RDATA_O == 8'h00 && !REG_HIT_O; endproperty
  a_h: assert property (p_h) else $error("unmapped");
endmodule // led_sink_chk
bind led_sink_current_control led_sink_chk CHK (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_HIT_O(REG_HIT_O),
  .DIM_TIMEOUT_I(DIM_TIMEOUT_I), .DIM_REQ_I(DIM_REQ_I), .BL_DIMMED_O(BL_DIMMED_O), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .FADE_CODE_I(FADE_CODE_I), .SINK_ENABLE_O(SINK_ENABLE_O),
  .SINK_CURRENT_UA_O(SINK_CURRENT_UA_O), .SINK_FADE_LAW_O(SINK_FADE_LAW_O));
`default_nettype wire

// ### host_model.sv
// Purpose: host side of the register port
// Assumes: core clock
// Notes: drives 1 ns after edges
`default_nettype none
module host_model (
  input wire logic clk_i, hit_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o, wdata_o,
  output logic wr_o, rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i) #1 addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i) #1 wr_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    @(posedge clk_i) #1 addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i) #1 rd_o = 1'b0;
    d = {hit_i, rdata_i};
  endtask
endmodule // host_model
`default_nettype wire

// ### led_sink_current_control_tb.sv
// Purpose: self-checking bench for the sink register bank
// Assumes: host model drives the register port
// Notes: 25 MHz clock
`default_nettype none
module led_sink_current_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK_I = 1'b0, RST_N_I = 1'b0, DIM_TIMEOUT_I = 1'b0, DIM_REQ_I = 1'b0;
  logic REG_WR_I, REG_RD_I, REG_HIT_O, BL_DIMMED_O;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, STEP_DWELL_O;
  logic [6:0] FADE_CODE_I = 7'h40, BL_ACTIVE_CODE_I = 7'h2a, BL_CODE_O, SINK_ENABLE_O;
  logic [14:0] SINK_CURRENT_UA_O;
  logic [1:0] SINK_FADE_LAW_O;
  logic [8:0] rv;
  logic [7:0] ta[3] = '{8'h0a, 8'h0f, 8'h10}, tm[3] = '{8'h7f, 8'h03, 8'h7f}, dw[4] = '{8'h01, 8'h01, 8'h08, 8'h09};
  int num_errors = 0, compares = 0;
  initial forever #20 CORE_CLK_I = ~CORE_CLK_I;
  host_model HOST (.clk_i(CORE_CLK_I), .hit_i(REG_HIT_O), .rdata_i(REG_RDATA_O), .addr_o(REG_ADDR_I),
    .wdata_o(REG_WDATA_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I));
  led_sink_current_control DUT (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_HIT_O(REG_HIT_O), .DIM_TIMEOUT_I(DIM_TIMEOUT_I), .DIM_REQ_I(DIM_REQ_I),
    .BL_ACTIVE_CODE_I(BL_ACTIVE_CODE_I), .BL_CODE_O(BL_CODE_O), .BL_DIMMED_O(BL_DIMMED_O),
    .FADE_CODE_I(FADE_CODE_I), .SINK_CURRENT_UA_O(SINK_CURRENT_UA_O), .STEP_DWELL_O(STEP_DWELL_O),
    .SINK_FADE_LAW_O(SINK_FADE_LAW_O), .SINK_ENABLE_O(SINK_ENABLE_O));
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic reset;
    @(posedge CORE_CLK_I) #1 RST_N_I = 1'b0;
    repeat (16) @(posedge CORE_CLK_I);
    #1 RST_N_I = 1'b1;
  endtask
  initial begin
    reset();
    for (int i = 0; i < 3; i++) begin
      HOST.rd(ta[i], rv);
      chk(rv, 32'h100);
      HOST.wr(ta[i], 8'hff);
      HOST.rd(ta[i], rv);
      chk(rv, {1'b1, tm[i]});
    end
    HOST.wr(8'h0b, 8'h00);
    HOST.rd(8'h0b, rv);
    chk(rv, 32'h000);
    HOST.rd(8'h0a, rv);
    chk(rv, 32'h17f);
    for (int l = 0; l < 4; l++) begin
      HOST.wr(8'h0f, 8'hfc | l[7:0]);
      @(posedge CORE_CLK_I) #1;
      chk(SINK_FADE_LAW_O, l);
      chk(SINK_CURRENT_UA_O, l == 0 ? 32'h3b0e : 32'h1dc2);
      chk(STEP_DWELL_O, dw[l]);
    end
    FADE_CODE_I = 7'h7f;
    @(posedge CORE_CLK_I) #1;
    chk(SINK_CURRENT_UA_O, 32'h7530);
    chk(STEP_DWELL_O, 32'h10);
    FADE_CODE_I = 7'h00;
    @(posedge CORE_CLK_I) #1;
    chk(SINK_CURRENT_UA_O, 32'h0);
    chk(STEP_DWELL_O, 32'h01);
    for (int n = 0; n < 8; n++) begin
      HOST.wr(8'h10, 8'h80 | (8'h01 << n));
      chk(SINK_ENABLE_O, (8'h01 << n) & 8'h7f);
    end
    chk({BL_DIMMED_O, BL_CODE_O}, 32'h2a);
    BL_ACTIVE_CODE_I = 7'h15;
    @(posedge CORE_CLK_I) #1;
    chk({BL_DIMMED_O, BL_CODE_O}, 32'h15);
    DIM_TIMEOUT_I = 1'b1;
    @(posedge CORE_CLK_I) #1 DIM_TIMEOUT_I = 1'b0;
    chk({BL_DIMMED_O, BL_CODE_O}, 32'hff);
    BL_ACTIVE_CODE_I = 7'h2a;
    @(posedge CORE_CLK_I) #1;
    chk({BL_DIMMED_O, BL_CODE_O}, 32'hff);
    reset();
    DIM_REQ_I = 1'b1;
    @(posedge CORE_CLK_I) #1 DIM_REQ_I = 1'b0;
    chk({BL_DIMMED_O, BL_CODE_O}, 32'h80);
    chk({SINK_FADE_LAW_O, SINK_ENABLE_O, STEP_DWELL_O}, 32'h001);
    conclude();
  end
endmodule // led_sink_current_control_tb
`default_nettype wire
